// [rtl/rcs_pkg.sv]
// Summary of operation
// - groups A, C, D, E: enable bit, reset off
// - group B has no bit, on unless power-off set
// - global power-off bit, reset 0, disables all
// - read-only soft-start field captured from strap
// - strap value copied into overrides five-eight
// - regulators two-four follow strap; one uses none
// - regulators five-eight follow their own override
// - overrides are 2-bit writable, same encoding
// - output eight mode bit: 0 current, 1 voltage
// - 4-bit led current scale, resets to full
// - accurate mode: act only on repeated writes
// - cold flag: 1 battery insertion, 0 button
// - shutdown flag after button held hold time
// - per-regulator scaling done status bit
// - overcurrent fault bit, not regulator seven
// - short-circuit fault bit, not regulator seven
// - overvoltage and undervoltage bit, all eight
// - thermal fault bit, not regulator seven
// - per-regulator summary fault bit
// - 8-bit fine voltage dac for regulator three
// - reached over serial bus, every byte acked
package rcs_pkg;
   // ---------------------------------------------------
   // serial link
   // ---------------------------------------------------
   localparam logic [6:0] DEV_ADDR = 7'h54;
   typedef enum logic [2:0] {
      S_IDLE, S_RX, S_ACK, S_TX, S_MACK
   } rcs_link_st_t;
   typedef enum logic [1:0] {PH_ADDR, PH_REG, PH_DATA} rcs_phase_t;
   localparam logic [3:0] BITS_BYTE = 4'h8;
   localparam logic [3:0] LAST_TX   = 4'h7;
   // ---------------------------------------------------
   // register offsets
   // ---------------------------------------------------
   localparam logic [7:0] OFS_GEN1   = 8'h01;
   localparam logic [7:0] OFS_GEN2   = 8'h02;
   localparam logic [7:0] OFS_GEN3   = 8'h03;
   localparam logic [7:0] OFS_REG8C  = 8'h16;
   localparam logic [7:0] OFS_SUMM   = 8'h19;
   localparam logic [7:0] OFS_DAC    = 8'h1A;
   localparam logic [7:0] OFS_ACCUR  = 8'h1B;
   localparam logic [7:0] STAT_OFS [8] = '{8'h05, 8'h07, 8'h09,
      8'h0B, 8'h0E, 8'h11, 8'h14, 8'h18};
   localparam logic [7:0] OVR_OFS [4] = '{8'h0D, 8'h10, 8'h13, 8'h17};
   // ---------------------------------------------------
   // field positions
   // ---------------------------------------------------
   localparam int SDD_LSB    = 2;
   localparam int POFF_BIT   = 4;
   localparam int COLD_BIT   = 3;
   localparam int SHTD_BIT   = 4;
   localparam int REG7_IDX   = 6;
   localparam logic [4:0] MASK_ALL  = 5'h1F;
   localparam logic [4:0] MASK_REG7 = 5'h03;
   // ---------------------------------------------------
   // reset values and encodings
   // ---------------------------------------------------
   localparam logic [3:0] GRP_RST  = 4'h0;
   localparam logic [3:0] LED_RST  = 4'hF;
   localparam logic [7:0] DAC_RST  = 8'h00;
   localparam logic [1:0] SS_RST   = 2'h0;
   localparam logic [1:0] SDD_1S   = 2'h0;
   localparam logic [1:0] SDD_0P5S = 2'h1;
   localparam logic [1:0] SDD_1P5S = 2'h2;
   localparam logic [1:0] SDD_2S   = 2'h3;
   localparam logic [1:0] SS_0P5MS = 2'h0;
   localparam logic [1:0] SS_2MS   = 2'h1;
   localparam logic [1:0] SS_8MS   = 2'h2;
   localparam logic [1:0] SS_32MS  = 2'h3;
   // ---------------------------------------------------
   // timing
   // ---------------------------------------------------
   localparam int CLK_HZ        = 50_000_000;
   localparam int HOLD_UNIT_MS  = 500;
   localparam int HOLD_UNIT_CYC = HOLD_UNIT_MS * (CLK_HZ / 1000);
endpackage : rcs_pkg

// [rtl/rcs_i2c_link.sv]
`timescale 1ns/1ps
`default_nettype none
module rcs_i2c_link (
   // clock and reset
   input  wire logic       mclk,
   input  wire logic       rst,
   // serial pins
   input  wire logic       scl_in,
   input  wire logic       sda_in,
   output logic            sda_out,
   output logic            sda_oe_n,
   // register side
   output logic            wr_stb,
   output logic [7:0]      wr_addr,
   output logic [7:0]      wr_data,
   output logic            rd_stb,
   output logic [7:0]      rd_addr,
   input  wire logic [7:0] rd_data
);
   rcs_pkg::rcs_link_st_t st_ff, nxt_st;
   rcs_pkg::rcs_phase_t   ph_ff, nxt_ph;
   logic [3:0] cnt_ff, nxt_cnt;
   logic [7:0] sh_ff, nxt_sh, ptr_ff, nxt_ptr;
   logic [7:0] wa_ff, nxt_wa, wd_ff, nxt_wd;
   logic       rw_ff, nxt_rw, oe_n_ff, nxt_oe_n, ws_ff, nxt_ws;
   logic       scl_q_ff, sda_q_ff, mack_ff, nxt_mack, load;
   logic       scl_rise, scl_fall, start, stop;

   assign scl_rise = scl_in & ~scl_q_ff;
   assign scl_fall = ~scl_in & scl_q_ff;
   assign start    = scl_in & scl_q_ff & sda_q_ff & ~sda_in;
   assign stop     = scl_in & scl_q_ff & ~sda_q_ff & sda_in;

   // ---------------------------------------------------
   // byte engine
   // ---------------------------------------------------
   always_comb begin
      nxt_st = st_ff;
      nxt_ph = ph_ff;
      nxt_cnt = cnt_ff;
      nxt_sh = sh_ff;
      nxt_ptr = ptr_ff;
      nxt_wa = wa_ff;
      nxt_wd = wd_ff;
      nxt_rw = rw_ff;
      nxt_oe_n = oe_n_ff;
      nxt_mack = mack_ff;
      nxt_ws = 1'b0;
      load = 1'b0;
      if (start) begin
         nxt_st = rcs_pkg::S_RX;
         nxt_ph = rcs_pkg::PH_ADDR;
         nxt_cnt = 4'h0;
         nxt_oe_n = 1'b1;
      end else if (stop) begin
         nxt_st = rcs_pkg::S_IDLE;
         nxt_oe_n = 1'b1;
      end else begin
         case (st_ff)
            rcs_pkg::S_RX: begin
               if (scl_rise) begin
                  nxt_sh = {sh_ff[6:0], sda_in};
                  nxt_cnt = cnt_ff + 4'h1;
               end else if (scl_fall && cnt_ff == rcs_pkg::BITS_BYTE) begin
                  nxt_cnt = 4'h0;
                  nxt_st = rcs_pkg::S_ACK;
                  nxt_oe_n = 1'b0;
                  if (ph_ff == rcs_pkg::PH_ADDR) begin
                     nxt_rw = sh_ff[0];
                     // foreign address: stay off the bus
                     if (sh_ff[7:1] != rcs_pkg::DEV_ADDR) begin
                        nxt_st = rcs_pkg::S_IDLE;
                        nxt_oe_n = 1'b1;
                     end
                  end else if (ph_ff == rcs_pkg::PH_REG) begin
                     nxt_ptr = sh_ff;
                  end else begin
                     nxt_ws = 1'b1;
                     nxt_wa = ptr_ff;
                     nxt_wd = sh_ff;
                     nxt_ptr = ptr_ff + 8'h01;
                  end
               end
            end
            rcs_pkg::S_ACK: begin
               if (scl_fall) begin
                  if (rw_ff && ph_ff == rcs_pkg::PH_ADDR) begin
                     load = 1'b1;
                  end else begin
                     nxt_oe_n = 1'b1;
                     nxt_st = rcs_pkg::S_RX;
                     nxt_ph = (ph_ff == rcs_pkg::PH_ADDR) ?
                        rcs_pkg::PH_REG : rcs_pkg::PH_DATA;
                  end
               end
            end
            rcs_pkg::S_TX: begin
               if (scl_fall) begin
                  if (cnt_ff == rcs_pkg::LAST_TX) begin
                     nxt_oe_n = 1'b1;
                     nxt_st = rcs_pkg::S_MACK;
                  end else begin
                     nxt_sh = {sh_ff[6:0], 1'b0};
                     nxt_oe_n = sh_ff[6];
                     nxt_cnt = cnt_ff + 4'h1;
                  end
               end
            end
            rcs_pkg::S_MACK: begin
               if (scl_rise) begin
                  nxt_mack = sda_in;
               end else if (scl_fall) begin
                  if (!mack_ff) begin
                     load = 1'b1;
                  end else begin
                     nxt_st = rcs_pkg::S_IDLE;
                  end
               end
            end
            default: nxt_st = rcs_pkg::S_IDLE;
         endcase
      end
      // read data is taken at the moment the byte starts
      if (load) begin
         nxt_sh = rd_data;
         nxt_oe_n = rd_data[7];
         nxt_ptr = ptr_ff + 8'h01;
         nxt_cnt = 4'h0;
         nxt_st = rcs_pkg::S_TX;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         st_ff <= rcs_pkg::S_IDLE;
         ph_ff <= rcs_pkg::PH_ADDR;
         cnt_ff <= 4'h0;
         sh_ff <= 8'h00;
         ptr_ff <= 8'h00;
         wa_ff <= 8'h00;
         wd_ff <= 8'h00;
         rw_ff <= 1'b0;
         oe_n_ff <= 1'b1;
         ws_ff <= 1'b0;
         mack_ff <= 1'b1;
         scl_q_ff <= 1'b1;
         sda_q_ff <= 1'b1;
      end else begin
         st_ff <= nxt_st;
         ph_ff <= nxt_ph;
         cnt_ff <= nxt_cnt;
         sh_ff <= nxt_sh;
         ptr_ff <= nxt_ptr;
         wa_ff <= nxt_wa;
         wd_ff <= nxt_wd;
         rw_ff <= nxt_rw;
         oe_n_ff <= nxt_oe_n;
         ws_ff <= nxt_ws;
         mack_ff <= nxt_mack;
         scl_q_ff <= scl_in;
         sda_q_ff <= sda_in;
      end
   end

   assign sda_out  = 1'b0;
   assign sda_oe_n = oe_n_ff;
   assign wr_stb   = ws_ff;
   assign wr_addr  = wa_ff;
   assign wr_data  = wd_ff;
   assign rd_stb   = load;
   assign rd_addr  = ptr_ff;

   // ---------------------------------------------------
   // checks
   // ---------------------------------------------------
   property p_ack_byte;
      @(posedge mclk) disable iff (rst)
      (st_ff == rcs_pkg::S_RX && scl_fall && !start && !stop &&
       cnt_ff == rcs_pkg::BITS_BYTE && ph_ff != rcs_pkg::PH_ADDR)
      |=> !sda_oe_n && st_ff == rcs_pkg::S_ACK;
   endproperty
   a_ack_byte: assert property (p_ack_byte)
      else $error("data byte not acknowledged");
endmodule : rcs_i2c_link
`default_nettype wire

// [rtl/rcs_regs.sv]
`timescale 1ns/1ps
`default_nettype none
module rcs_regs #(
   parameter int HOLD_UNIT_CYC = rcs_pkg::HOLD_UNIT_CYC,
   parameter int CNT_W         = 27
) (
   // clock and reset
   input  wire logic       mclk,
   input  wire logic       rst,
   // serial pins
   input  wire logic       scl_in,
   input  wire logic       sda_in,
   output logic            sda_out,
   output logic            sda_oe_n,
   // straps and button
   input  wire logic [1:0] softstart_strap,
   input  wire logic       cold_start_in,
   input  wire logic       power_button_n,
   // regulator monitors
   input  wire logic [7:0] dvs_done_in,
   input  wire logic [7:0] ov_in,
   input  wire logic [7:0] uv_in,
   input  wire logic [7:0] ilim_in,
   input  wire logic [7:0] sc_in,
   input  wire logic [7:0] tsd_in,
   // controls to the regulators
   output logic [3:0]      group_enable_bits,
   output logic            always_on_group,
   output logic            global_power_off,
   output logic [1:0]      strapped_softstart_value,
   output logic [7:0]      softstart_override,
   output logic            output_eight_regulation_select,
   output logic [3:0]      led_current_scale,
   output logic [7:0]      fine_voltage_dac,
   // status to the system
   output logic            shutdown_flag,
   output logic [7:0]      summary_fault_bit
);
   logic       wr_stb, rd_stb, commit, hit;
   logic [7:0] wr_addr, wr_data, rd_addr, rd_data;
   logic [CNT_W-1:0] hold_cyc;

   rcs_i2c_link u_rcs_i2c_link (
      .mclk    (mclk),
      .rst     (rst),
      .scl_in  (scl_in),
      .sda_in  (sda_in),
      .sda_out (sda_out),
      .sda_oe_n(sda_oe_n),
      .wr_stb  (wr_stb),
      .wr_addr (wr_addr),
      .wr_data (wr_data),
      .rd_stb  (rd_stb),
      .rd_addr (rd_addr),
      .rd_data (rd_data)
   );

   // ---------------------------------------------------
   // state
   // ---------------------------------------------------
   logic [3:0]       grp_ff, nxt_grp, en_ff, nxt_en, led_ff, nxt_led;
   logic             poff_ff, nxt_poff, aon_ff, nxt_aon;
   logic [1:0]       sdd_ff, nxt_sdd, ss_ff, nxt_ss;
   logic [3:0][1:0]  ovr_ff, nxt_ovr;
   logic             mode_ff, nxt_mode, acc_ff, nxt_acc;
   logic             cap_ff, nxt_cap, cold_ff, nxt_cold;
   logic             shtd_ff, nxt_shtd;
   logic [7:0]       dac_ff, nxt_dac;
   logic [7:0][4:0]  flt_ff, nxt_flt;
   logic             pv_ff, nxt_pv;
   logic [15:0]      pend_ff, nxt_pend;
   logic [CNT_W-1:0] cnt_ff, nxt_cnt;

   // ---------------------------------------------------
   // accurate mode filter
   // ---------------------------------------------------
   // a lone write, or a pair that disagrees, is dropped
   always_comb begin
      nxt_pv = pv_ff;
      nxt_pend = pend_ff;
      commit = 1'b0;
      if (!acc_ff) begin
         nxt_pv = 1'b0;
         commit = wr_stb;
      end else if (wr_stb) begin
         if (pv_ff && pend_ff == {wr_addr, wr_data}) begin
            commit = 1'b1;
            nxt_pv = 1'b0;
         end else begin
            nxt_pv = 1'b1;
            nxt_pend = {wr_addr, wr_data};
         end
      end
   end

   // ---------------------------------------------------
   // shutdown hold timer
   // ---------------------------------------------------
   always_comb begin
      case (sdd_ff)
         rcs_pkg::SDD_0P5S: hold_cyc = CNT_W'(HOLD_UNIT_CYC);
         rcs_pkg::SDD_1P5S: hold_cyc = CNT_W'(3 * HOLD_UNIT_CYC);
         rcs_pkg::SDD_2S:   hold_cyc = CNT_W'(4 * HOLD_UNIT_CYC);
         default:           hold_cyc = CNT_W'(2 * HOLD_UNIT_CYC);
      endcase
      hit = !power_button_n && cnt_ff < hold_cyc &&
            cnt_ff + CNT_W'(1) >= hold_cyc;
      if (power_button_n) begin
         nxt_cnt = '0;
      end else if (cnt_ff >= hold_cyc) begin
         nxt_cnt = cnt_ff; // saturate: flag set once per press
      end else begin
         nxt_cnt = cnt_ff + CNT_W'(1);
      end
   end

   // ---------------------------------------------------
   // register writes, captures and flags
   // ---------------------------------------------------
   always_comb begin
      nxt_grp = grp_ff;
      nxt_poff = poff_ff;
      nxt_sdd = sdd_ff;
      nxt_ss = ss_ff;
      nxt_ovr = ovr_ff;
      nxt_mode = mode_ff;
      nxt_led = led_ff;
      nxt_acc = acc_ff;
      nxt_cap = cap_ff;
      nxt_cold = cold_ff;
      nxt_shtd = shtd_ff;
      nxt_dac = dac_ff;
      nxt_flt = flt_ff;
      if (commit) begin
         case (wr_addr)
            rcs_pkg::OFS_GEN1: nxt_sdd = wr_data[rcs_pkg::SDD_LSB +: 2];
            rcs_pkg::OFS_GEN2: begin
               nxt_grp = wr_data[3:0];
               nxt_poff = wr_data[rcs_pkg::POFF_BIT];
            end
            rcs_pkg::OFS_GEN3: begin
               // flags clear on a 0 write; 1 is ignored
               if (!wr_data[rcs_pkg::COLD_BIT]) nxt_cold = 1'b0;
               if (!wr_data[rcs_pkg::SHTD_BIT]) nxt_shtd = 1'b0;
            end
            rcs_pkg::OFS_REG8C: begin
               nxt_mode = wr_data[0];
               nxt_led = wr_data[4:1];
            end
            rcs_pkg::OFS_DAC: nxt_dac = wr_data;
            rcs_pkg::OFS_ACCUR: nxt_acc = wr_data[0];
            default: nxt_dac = dac_ff;
         endcase
         for (int k = 0; k < 4; k++) begin
            if (wr_addr == rcs_pkg::OVR_OFS[k]) begin
               nxt_ovr[k] = wr_data[1:0];
            end
         end
      end
      // one capture after reset release; strap read once only
      if (!cap_ff) begin
         nxt_cap = 1'b1;
         nxt_ss = softstart_strap;
         nxt_cold = cold_start_in;
         for (int k = 0; k < 4; k++) begin
            nxt_ovr[k] = softstart_strap;
         end
      end
      if (hit) nxt_shtd = 1'b1;
      // faults are sticky, cleared by reading; a new hit wins
      for (int i = 0; i < 8; i++) begin
         if (rd_stb && rd_addr == rcs_pkg::STAT_OFS[i]) begin
            nxt_flt[i] = 5'h00;
         end
         nxt_flt[i] = nxt_flt[i] | ({tsd_in[i], sc_in[i], ilim_in[i],
            uv_in[i], ov_in[i]} & ((i == rcs_pkg::REG7_IDX) ?
            rcs_pkg::MASK_REG7 : rcs_pkg::MASK_ALL));
      end
      // power-off holds every group down, group B included
      nxt_en = poff_ff ? 4'h0 : grp_ff;
      nxt_aon = !poff_ff;
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         grp_ff <= rcs_pkg::GRP_RST;
         en_ff <= rcs_pkg::GRP_RST;
         poff_ff <= 1'b0;
         aon_ff <= 1'b1;
         sdd_ff <= rcs_pkg::SDD_1S;
         ss_ff <= rcs_pkg::SS_RST;
         ovr_ff <= '0;
         mode_ff <= 1'b0;
         led_ff <= rcs_pkg::LED_RST;
         acc_ff <= 1'b0;
         cap_ff <= 1'b0;
         cold_ff <= 1'b0;
         shtd_ff <= 1'b0;
         dac_ff <= rcs_pkg::DAC_RST;
         flt_ff <= '0;
         pv_ff <= 1'b0;
         pend_ff <= 16'h0000;
         cnt_ff <= '0;
      end else begin
         grp_ff <= nxt_grp;
         en_ff <= nxt_en;
         poff_ff <= nxt_poff;
         aon_ff <= nxt_aon;
         sdd_ff <= nxt_sdd;
         ss_ff <= nxt_ss;
         ovr_ff <= nxt_ovr;
         mode_ff <= nxt_mode;
         led_ff <= nxt_led;
         acc_ff <= nxt_acc;
         cap_ff <= nxt_cap;
         cold_ff <= nxt_cold;
         shtd_ff <= nxt_shtd;
         dac_ff <= nxt_dac;
         flt_ff <= nxt_flt;
         pv_ff <= nxt_pv;
         pend_ff <= nxt_pend;
         cnt_ff <= nxt_cnt;
      end
   end

   // ---------------------------------------------------
   // read side
   // ---------------------------------------------------
   always_comb begin
      rd_data = 8'h00;
      case (rd_addr)
         rcs_pkg::OFS_GEN1: rd_data = {4'h0, sdd_ff, 2'b00};
         rcs_pkg::OFS_GEN2: rd_data = {3'h0, poff_ff, grp_ff};
         rcs_pkg::OFS_GEN3:
            rd_data = {3'h0, shtd_ff, cold_ff, 1'b0, ss_ff};
         rcs_pkg::OFS_REG8C: rd_data = {3'h0, led_ff, mode_ff};
         rcs_pkg::OFS_SUMM: rd_data = summary_fault_bit;
         rcs_pkg::OFS_DAC: rd_data = dac_ff;
         rcs_pkg::OFS_ACCUR: rd_data = {7'h00, acc_ff};
         default: rd_data = 8'h00;
      endcase
      for (int i = 0; i < 8; i++) begin
         if (rd_addr == rcs_pkg::STAT_OFS[i]) begin
            rd_data = {2'b00, flt_ff[i], dvs_done_in[i]};
         end
      end
      for (int k = 0; k < 4; k++) begin
         if (rd_addr == rcs_pkg::OVR_OFS[k]) begin
            rd_data = {6'h00, ovr_ff[k]};
         end
      end
   end

   // ---------------------------------------------------
   // outputs
   // ---------------------------------------------------
   // regulator one takes no soft-start code at all
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         summary_fault_bit[i] = |flt_ff[i];
      end
   end
   assign group_enable_bits = en_ff;
   assign always_on_group = aon_ff;
   assign global_power_off = poff_ff;
   assign strapped_softstart_value = ss_ff;
   assign softstart_override = ovr_ff;
   assign output_eight_regulation_select = mode_ff;
   assign led_current_scale = led_ff;
   assign fine_voltage_dac = dac_ff;
   assign shutdown_flag = shtd_ff;

   // ---------------------------------------------------
   // checks
   // ---------------------------------------------------
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (rst);

   property p_grp_wr;
      commit && wr_addr == rcs_pkg::OFS_GEN2 && !wr_data[4]
      |=> ##1 group_enable_bits == $past(wr_data[3:0], 2);
   endproperty
   a_grp_wr: assert property (p_grp_wr)
      else $error("group enables do not follow write");

   property p_always_on_group;
      !global_power_off |=> always_on_group;
   endproperty
   a_always_on_group: assert property (p_always_on_group)
      else $error("group B off without power-off");

   property p_global_power_off;
      global_power_off |=> group_enable_bits == 4'h0 && !always_on_group;
   endproperty
   a_global_power_off: assert property (p_global_power_off)
      else $error("group still on under power-off");

   property p_ss_stable;
      cap_ff && $past(cap_ff) |-> $stable(strapped_softstart_value);
   endproperty
   a_ss_stable: assert property (p_ss_stable)
      else $error("strapped soft-start changed");

   property p_ss_copy;
      $rose(cap_ff) |-> softstart_override == {4{strapped_softstart_value}}
         && strapped_softstart_value == $past(softstart_strap);
   endproperty
   a_ss_copy: assert property (p_ss_copy)
      else $error("overrides not seeded from strap");

   property p_ovr_wr;
      cap_ff && commit && wr_addr == rcs_pkg::OVR_OFS[3]
      |=> softstart_override[7:6] == $past(wr_data[1:0]);
   endproperty
   a_ovr_wr: assert property (p_ovr_wr)
      else $error("override write lost");

   property p_rst_vals;
      $past(rst) |-> !output_eight_regulation_select &&
         led_current_scale == 4'hF;
   endproperty
   a_rst_vals: assert property (p_rst_vals)
      else $error("mode or led scale reset value wrong");

   property p_acc_single;
      acc_ff && wr_stb && !pv_ff |-> !commit ##1 pv_ff;
   endproperty
   a_acc_single: assert property (p_acc_single)
      else $error("single write acted on in accurate mode");

   property p_cold;
      $rose(cap_ff) |-> cold_ff == $past(cold_start_in);
   endproperty
   a_cold: assert property (p_cold)
      else $error("cold flag not captured");

   property p_shtd;
      $rose(shutdown_flag) |-> !$past(power_button_n) &&
         $past(cnt_ff) + CNT_W'(1) == $past(hold_cyc);
   endproperty
   a_shtd: assert property (p_shtd)
      else $error("shutdown flag set early");

   property p_flt;
      ov_in[2] |=> summary_fault_bit[2];
   endproperty
   a_flt: assert property (p_flt)
      else $error("overvoltage not reported");

   c_acc_commit: cover property (acc_ff && commit);
   c_shtd: cover property ($rose(shutdown_flag));
   c_rd_clear: cover property (rd_stb && rd_addr == rcs_pkg::STAT_OFS[0]);
endmodule : rcs_regs
`default_nettype wire

// [verif/rcs_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
module rcs_host_model (
   // serial bus
   input  wire logic mclk,
   input  wire logic sda_in,
   output var logic  scl = 1'b1,
   output var logic  sda = 1'b1
);
   int nak_cnt = 0;
   // four mclk a phase, margin over the three needed
   task ph(input logic c, input logic d);
      scl <= c;
      sda <= d;
      repeat (4) @(posedge mclk);
   endtask : ph
   // data only moves while the clock is low
   task bit_out(input logic d);
      ph(1'b0, sda);
      ph(1'b0, d);
      ph(1'b1, d);
   endtask : bit_out
   task tx(input logic [7:0] b);
      for (int i = 7; i >= 0; i--) bit_out(b[i]);
      bit_out(1'b1);
      if (sda_in) nak_cnt++;
   endtask : tx
   task head(input logic [7:0] r);
      bit_out(1'b1);
      ph(1'b1, 1'b0);
      tx(8'hA8);
      tx(r);
   endtask : head
   task stop();
      bit_out(1'b0);
      ph(1'b1, 1'b1);
   endtask : stop
   task wr(input logic [7:0] r, d);
      head(r);
      tx(d);
      stop();
   endtask : wr
   task rd(input logic [7:0] r, output logic [7:0] d);
      head(r);
      bit_out(1'b1);
      ph(1'b1, 1'b0);
      tx(8'hA9);
      for (int i = 7; i >= 0; i--) begin
         bit_out(1'b1);
         d[i] = sda_in;
      end
      bit_out(1'b1);
      stop();
   endtask : rd
endmodule : rcs_host_model
`default_nettype wire

// [verif/tb_rcs_regs.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_rcs_regs;
   logic       mclk, rst, scl, sda, bus_sda, sda_out, sda_oe_n;
   logic       cold_start_in, power_button_n, global_power_off;
   logic       always_on_group, output_eight_regulation_select;
   logic       shutdown_flag;
   logic [1:0] softstart_strap, strapped_softstart_value;
   logic [3:0] group_enable_bits, led_current_scale;
   logic [7:0] dvs_done_in, ov_in, uv_in, ilim_in, sc_in, tsd_in, rv;
   logic [7:0] softstart_override, fine_voltage_dac, summary_fault_bit;
   int         bad_count = 0, checks_done = 0, cyc = 0;
   assign bus_sda = sda & (sda_oe_n | sda_out);
   rcs_regs #(.HOLD_UNIT_CYC(20)) u_rcs_regs (
      .mclk, .rst, .scl_in(scl), .sda_in(bus_sda), .sda_out, .sda_oe_n,
      .softstart_strap, .cold_start_in, .power_button_n, .dvs_done_in,
      .ov_in, .uv_in, .ilim_in, .sc_in, .tsd_in, .group_enable_bits,
      .always_on_group, .global_power_off, .strapped_softstart_value,
      .softstart_override, .output_eight_regulation_select,
      .led_current_scale, .fine_voltage_dac, .shutdown_flag,
      .summary_fault_bit);
   rcs_host_model u_rcs_host_model (.mclk, .sda_in(bus_sda), .scl, .sda);
   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end
   // whole run is near 9000 cycles
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         bad_count++;
         finish_test();
      end
   end
   task finish_test();
      $display("checks %0d errors %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : finish_test
   task chk(input logic [7:0] got, exp);
      checks_done++;
      if (got !== exp) begin
         bad_count++;
         $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task wr(input logic [7:0] r, d);
      u_rcs_host_model.wr(r, d);
   endtask : wr
   task rdc(input logic [7:0] r, e);
      u_rcs_host_model.rd(r, rv);
      chk(rv, e);
   endtask : rdc
   // ---------------------------------------------------
   // main sequence
   // ---------------------------------------------------
   initial begin
      {dvs_done_in, ov_in, uv_in, ilim_in, sc_in, tsd_in} = '0;
      softstart_strap = 2'h2;
      cold_start_in = 1'b1;
      power_button_n = 1'b1;
      rst = 1'b1;
      repeat (5) @(posedge mclk);
      rst <= 1'b0;
      repeat (4) @(posedge mclk);
      chk({group_enable_bits, 3'h0, always_on_group}, 8'h01);
      chk({global_power_off, led_current_scale}, 8'h0F);
      chk(output_eight_regulation_select, 8'h00);
      chk(strapped_softstart_value, 8'h02);
      chk(softstart_override, 8'hAA);
      rdc(8'h03, 8'h0A);
      wr(8'h03, 8'h03);
      rdc(8'h03, 8'h02);
      wr(8'h16, 8'h0B);
      chk(led_current_scale, 8'h05);
      chk(output_eight_regulation_select, 8'h01);
      wr(8'h02, 8'h0F);
      chk(group_enable_bits, 8'h0F);
      wr(8'h02, 8'h1F);
      chk({group_enable_bits, always_on_group, global_power_off}, 8'h01);
      wr(8'h17, 8'h03);
      chk(softstart_override, 8'hEA);
      wr(8'h1A, 8'hC8);
      rdc(8'h1A, 8'hC8);
      wr(8'h1B, 8'h01);
      wr(8'h1A, 8'hC4);
      chk(fine_voltage_dac, 8'hC8);
      wr(8'h1A, 8'hC4);
      chk(fine_voltage_dac, 8'hC4);
      dvs_done_in <= 8'h04;
      {ov_in, uv_in, ilim_in, sc_in, tsd_in} <= {32'h04014101, 8'h01};
      repeat (2) @(posedge mclk);
      {ov_in, uv_in, ilim_in, sc_in, tsd_in} <= '0;
      repeat (2) @(posedge mclk);
      chk(summary_fault_bit, 8'h05);
      rdc(8'h05, 8'h3C);
      rdc(8'h09, 8'h03);
      rdc(8'h14, 8'h00);
      chk(summary_fault_bit, 8'h00);
      power_button_n <= 1'b0;
      repeat (30) @(posedge mclk);
      chk(shutdown_flag, 8'h00);
      repeat (20) @(posedge mclk);
      chk(shutdown_flag, 8'h01);
      power_button_n <= 1'b1;
      rdc(8'h03, 8'h12);
      // accurate mode still on: every write goes twice
      wr(8'h01, 8'h04);
      wr(8'h01, 8'h04);
      wr(8'h03, 8'h00);
      wr(8'h03, 8'h00);
      rdc(8'h01, 8'h04);
      power_button_n <= 1'b0;
      repeat (15) @(posedge mclk);
      chk(shutdown_flag, 8'h00);
      repeat (10) @(posedge mclk);
      chk(shutdown_flag, 8'h01);
      power_button_n <= 1'b1;
      chk(8'(u_rcs_host_model.nak_cnt), 8'h00);
      finish_test();
   end
endmodule : tb_rcs_regs
`default_nettype wire
